// ==== include/eas_params.svh ====
// Summary of operation
// RULE1: Judge toner level from the toner-low input while the supply motor runs.
// RULE2: Toner low with drum turning switches the toner supply motor on.
// RULE3: Still low after 100 s total supply time: add-toner, stop after cycle.
// RULE4: Supply-time accumulator advances only while the drum motor turns; else holds.
// RULE5: Power switch or any door switch off clears the accumulator.
// RULE6: After power-up, counting restarts from zero on toner low with drum turning.
// RULE7: Engine image counter advances once per printed image.
// RULE8: With duplex fitted, duplex counter advances per sheet entering duplex.
// RULE9: Duplexed sheet advances engine counter again on its return pass.
// RULE10: Open counter circuit raises an error code and halts printing.
// RULE11: Counter open error stays latched until a power cycle.
// RULE12: Low comparator result means heat demand, drum below 44C target.
// RULE13: With heat demand, heater trigger pulses at each AC zero crossing.
// RULE14: Without heat demand, heater trigger is held off.
// RULE15: Add-toner indication holds until the accumulator is cleared by switches.
`ifndef EAS_PARAMS_SVH
`define EAS_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define EAS_OFS_CTRL 8'h00
`define EAS_OFS_STATUS 8'h04
`define EAS_OFS_IRQ_STAT 8'h08
`define EAS_OFS_IRQ_CLR 8'h0C
`define EAS_OFS_IRQ_EN 8'h10
`define EAS_OFS_ACCUM 8'h14
`define EAS_OFS_ENG_COUNT 8'h18
`define EAS_OFS_DUP_COUNT 8'h1C

// ****************************************
// Field positions
// ****************************************
`define EAS_CTRL_DUPLEX_BIT 0
`define EAS_ST_ADD_TONER_BIT 0
`define EAS_ST_HALT_BIT 1
`define EAS_ST_ENG_FAULT_BIT 2
`define EAS_ST_DUP_FAULT_BIT 3
`define EAS_ST_HEAT_DEMAND_BIT 4
`define EAS_ST_SUPPLY_ON_BIT 5
`define EAS_ST_DRUM_RUN_BIT 6
`define EAS_ST_ERR_CODE_LSB 8
`define EAS_IRQ_ADD_TONER_BIT 0
`define EAS_IRQ_ENG_FAULT_BIT 1
`define EAS_IRQ_DUP_FAULT_BIT 2
`define EAS_IRQ_WIDTH 3

// ****************************************
// Reset values and codes
// ****************************************
`define EAS_CTRL_RESET 1'b0
`define EAS_IRQ_EN_RESET 3'h0
`define EAS_ERR_NONE 4'h0
`define EAS_ERR_ENG_COUNTER 4'h1
`define EAS_ERR_DUP_COUNTER 4'h2

// ****************************************
// Timing
// ****************************************
`define EAS_CLK_MHZ 200
`define EAS_TICK_NS 1000000
`define EAS_TICK_CYCLES (`EAS_TICK_NS * `EAS_CLK_MHZ / 1000)
`define EAS_SUPPLY_LIMIT_S 100
`define EAS_SUPPLY_LIMIT_TICKS (`EAS_SUPPLY_LIMIT_S * 1000)
`define EAS_HTR_PULSE_NS 10000
`define EAS_HTR_PULSE_CYCLES (`EAS_HTR_PULSE_NS * `EAS_CLK_MHZ / 1000)
`define EAS_CNT_ON_TICKS 20
`define EAS_CNT_OFF_TICKS 20

`endif

// ==== include/eas_pkg.sv ====
package eas_pkg;

  // Toner supervisor: idle, counting supply time, empty reported
  typedef enum logic [1:0] {
    EAS_TS_IDLE = 2'b00,
    EAS_TS_TRACK = 2'b01,
    EAS_TS_EMPTY = 2'b11
  } eas_toner_state_t;

  // Mechanical counter coil phases
  typedef enum logic [1:0] {
    EAS_CD_IDLE = 2'b00,
    EAS_CD_ON = 2'b01,
    EAS_CD_OFF = 2'b11
  } eas_cnt_state_t;

  typedef logic [16:0] eas_accum_t;

endpackage

// ==== hdl/eas_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module eas_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/eas_cnt_drv.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eas_params.svh"

module eas_cnt_drv
  import eas_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic tick,
  // Requests and circuit sense
  input wire logic [1:0] incr,
  input wire logic open_sense,
  // Coil drive and status
  output logic coil_on,
  output logic fault,
  output logic [31:0] total
);

  eas_cnt_state_t state_r, state_nxt;
  logic [3:0] pend_r;
  logic [5:0] ticks_r;
  logic [2:0] pend_sum;
  logic start;
  logic phase_done;

  // Backlog absorbs two requests in one cycle; saturates rather than wraps
  assign start = (state_r == EAS_CD_IDLE) && (pend_r != 4'h0) && !fault;
  assign phase_done = tick && (ticks_r == 6'h00);
  assign pend_sum = {1'b0, incr[1]} + {2'b00, incr[0]};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EAS_CD_IDLE: if (start) state_nxt = EAS_CD_ON;
      EAS_CD_ON: if (phase_done) state_nxt = EAS_CD_OFF;
      EAS_CD_OFF: if (phase_done) state_nxt = EAS_CD_IDLE;
      default: state_nxt = EAS_CD_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= EAS_CD_IDLE;
      pend_r <= 4'h0;
      ticks_r <= 6'h00;
      fault <= 1'b0;
      total <= 32'h0000_0000;
    end else if (ce) begin
      state_r <= state_nxt;
      if (start) ticks_r <= 6'(`EAS_CNT_ON_TICKS - 1);
      else if (phase_done && state_r == EAS_CD_ON)
        ticks_r <= 6'(`EAS_CNT_OFF_TICKS - 1);
      else if (tick && ticks_r != 6'h00) ticks_r <= ticks_r - 6'h01;
      if (pend_r > 4'hD && pend_sum > {2'b00, start}) pend_r <= 4'hF;
      else pend_r <= pend_r + {1'b0, pend_sum} - {3'b000, start};
      if (start) total <= total + 32'h0000_0001;
      // RULE10 RULE11: fault latch, cleared only by reset
      if (open_sense) fault <= 1'b1;
    end
  end

  assign coil_on = (state_r == EAS_CD_ON);

endmodule
`default_nettype wire

// ==== hdl/eas_top.sv ====
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "eas_params.svh"

module eas_top
  import eas_pkg::*;
#(
  parameter int TICK_CYCLES = `EAS_TICK_CYCLES,
  parameter int HTR_PULSE_CYCLES = `EAS_HTR_PULSE_CYCLES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Toner and switch pins
  input wire logic toner_low_level_n,
  input wire logic drum_motor_run,
  input wire logic power_sw_on,
  input wire logic doors_closed,
  output logic toner_motor_on,
  output logic add_toner,
  // Engine events, same clock
  input wire logic print_cycle_active,
  input wire logic image_done,
  input wire logic return_pass_image,
  input wire logic duplex_sheet_in,
  output logic halt_print,
  output logic [3:0] error_code,
  // Mechanical counters
  input wire logic eng_cnt_open,
  input wire logic dup_cnt_open,
  output logic eng_cnt_coil,
  output logic dup_cnt_coil,
  // Drum heater
  input wire logic drum_temp_sense_n,
  input wire logic ac_zero_cross,
  output logic heater_trigger_switch,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pins_raw, pins_s;
  logic toner_low_s, drum_run_s, power_s, doors_s;
  logic temp_low_s, zc_s, eng_open_s, dup_open_s;

  assign pins_raw = {dup_cnt_open, eng_cnt_open, ac_zero_cross,
                     !drum_temp_sense_n, doors_closed, power_sw_on,
                     drum_motor_run};

  eas_sync #(.WIDTH(NSYNC)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // Toner level has its own stage pair so it resets to "not low"
  logic toner_meta_r, toner_n_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toner_meta_r <= 1'b1;
      toner_n_r <= 1'b1;
    end else if (ce) begin
      toner_meta_r <= toner_low_level_n;
      toner_n_r <= toner_meta_r;
    end
  end

  assign toner_low_s = !toner_n_r;
  assign drum_run_s = pins_s[0];
  assign power_s = pins_s[1];
  assign doors_s = pins_s[2];
  assign temp_low_s = pins_s[3];
  assign zc_s = pins_s[4];
  assign eng_open_s = pins_s[5];
  assign dup_open_s = pins_s[6];

  // ****************************************
  // Millisecond tick
  // ****************************************
  // A shared prescaler keeps the 100 s accumulator and coil timing narrow
  logic [17:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == 18'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_r <= 18'h00000;
    else if (ce) tick_cnt_r <= tick ? 18'h00000 : tick_cnt_r + 18'h00001;
  end

  // ****************************************
  // Toner empty supervisor
  // ****************************************
  eas_toner_state_t ts_r, ts_nxt;
  eas_accum_t accum_r;
  logic switches_off, supply_run, accum_full, accum_adv;

  // RULE5: any switch opening clears supply timing
  assign switches_off = !power_s || !doors_s;
  // RULE2: supply motor runs on toner low while drum turns
  assign supply_run = (ts_r == EAS_TS_TRACK) && drum_run_s && toner_low_s;
  // RULE4: time accrues only with the drum turning
  assign accum_adv = supply_run && tick && !accum_full;
  assign accum_full = (accum_r >= eas_accum_t'(`EAS_SUPPLY_LIMIT_TICKS));

  always_comb begin
    ts_nxt = ts_r;
    unique case (ts_r)
      EAS_TS_IDLE: begin
        // RULE6: counting starts only on low level with drum running
        if (!switches_off && toner_low_s && drum_run_s)
          ts_nxt = EAS_TS_TRACK;
      end
      EAS_TS_TRACK: begin
        // RULE1 RULE3: level judged while the motor is running
        if (switches_off) ts_nxt = EAS_TS_IDLE;
        else if (supply_run && accum_full) ts_nxt = EAS_TS_EMPTY;
      end
      EAS_TS_EMPTY: begin
        // RULE15: indication holds until switch clear
        if (switches_off) ts_nxt = EAS_TS_IDLE;
      end
      default: ts_nxt = EAS_TS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_r <= EAS_TS_IDLE;
      accum_r <= '0;
    end else if (ce) begin
      ts_r <= ts_nxt;
      // RULE5: clear to zero on switch off
      if (switches_off) accum_r <= '0;
      else if (accum_adv) accum_r <= accum_r + eas_accum_t'(1);
    end
  end

  assign toner_motor_on = supply_run;
  assign add_toner = (ts_r == EAS_TS_EMPTY);

  // ****************************************
  // Counter drivers
  // ****************************************
  logic duplex_fitted_r;
  logic eng_fault, dup_fault;
  logic [31:0] eng_total, dup_total;
  logic [1:0] eng_incr, dup_incr;

  // RULE7 RULE9: one step per image, a second on the return pass
  assign eng_incr = {return_pass_image && duplex_fitted_r, image_done};
  // RULE8: duplex counter only when the unit is fitted
  assign dup_incr = {1'b0, duplex_sheet_in && duplex_fitted_r};

  eas_cnt_drv u_eng_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick(tick),
    .incr(eng_incr),
    .open_sense(eng_open_s),
    .coil_on(eng_cnt_coil),
    .fault(eng_fault),
    .total(eng_total)
  );

  eas_cnt_drv u_dup_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick(tick),
    .incr(dup_incr),
    .open_sense(dup_open_s && duplex_fitted_r),
    .coil_on(dup_cnt_coil),
    .fault(dup_fault),
    .total(dup_total)
  );

  // ****************************************
  // Print halt and error code
  // ****************************************
  logic toner_stop_r;
  logic [3:0] err_nxt;

  // RULE10: first fault wins the error code
  assign err_nxt = eng_fault ? `EAS_ERR_ENG_COUNTER :
                   dup_fault ? `EAS_ERR_DUP_COUNTER : `EAS_ERR_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toner_stop_r <= 1'b0;
      error_code <= `EAS_ERR_NONE;
      halt_print <= 1'b0;
    end else if (ce) begin
      // RULE3: stop waits for the running print cycle to end
      if (!add_toner) toner_stop_r <= 1'b0;
      else if (!print_cycle_active) toner_stop_r <= 1'b1;
      if (!(|error_code)) error_code <= err_nxt;
      // RULE10: counter fault halts at once
      halt_print <= toner_stop_r || eng_fault || dup_fault;
    end
  end

  // ****************************************
  // Drum heater trigger
  // ****************************************
  logic zc_d_r, zc_edge, heat_demand;
  logic [11:0] htr_cnt_r;

  // RULE12: low comparator output is a heat demand
  assign heat_demand = temp_low_s;
  assign zc_edge = zc_s && !zc_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zc_d_r <= 1'b0;
      htr_cnt_r <= 12'h000;
      heater_trigger_switch <= 1'b0;
    end else if (ce) begin
      zc_d_r <= zc_s;
      if (!heat_demand) begin
        // RULE14: no demand, trigger held off
        htr_cnt_r <= 12'h000;
        heater_trigger_switch <= 1'b0;
      end else if (zc_edge) begin
        // RULE13: fire once per zero crossing
        htr_cnt_r <= 12'(HTR_PULSE_CYCLES - 1);
        heater_trigger_switch <= 1'b1;
      end else if (htr_cnt_r != 12'h000) begin
        htr_cnt_r <= htr_cnt_r - 12'h001;
      end else begin
        heater_trigger_switch <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [`EAS_IRQ_WIDTH-1:0] irq_stat_r, irq_en_r, irq_evt, irq_clr;
  logic add_toner_d_r, eng_fault_d_r, dup_fault_d_r;

  assign irq_evt = {dup_fault && !dup_fault_d_r,
                    eng_fault && !eng_fault_d_r,
                    add_toner && !add_toner_d_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      add_toner_d_r <= 1'b0;
      eng_fault_d_r <= 1'b0;
      dup_fault_d_r <= 1'b0;
      irq_stat_r <= '0;
    end else if (ce) begin
      add_toner_d_r <= add_toner;
      eng_fault_d_r <= eng_fault;
      dup_fault_d_r <= dup_fault;
      // New event beats a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  logic addr_ok, wr_ph_r;
  logic [7:0] wr_ofs_r;
  logic [31:0] status_w, rd_mux;

  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign status_w = {20'h00000, error_code, 1'b0,
                     drum_run_s, toner_motor_on, heat_demand,
                     dup_fault, eng_fault, halt_print, add_toner};

  function automatic logic [31:0] rd_sel(input logic [7:0] ofs,
                                         input logic [31:0] st,
                                         input logic [31:0] cnt_e,
                                         input logic [31:0] cnt_d);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      `EAS_OFS_CTRL: v = {31'h0000_0000, duplex_fitted_r};
      `EAS_OFS_STATUS: v = st;
      `EAS_OFS_IRQ_STAT: v = {29'h0000_0000, irq_stat_r};
      `EAS_OFS_IRQ_EN: v = {29'h0000_0000, irq_en_r};
      `EAS_OFS_ACCUM: v = {15'h0000, accum_r};
      `EAS_OFS_ENG_COUNT: v = cnt_e;
      `EAS_OFS_DUP_COUNT: v = cnt_d;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign rd_mux = rd_sel({haddr[7:2], 2'b00}, status_w, eng_total,
                         dup_total);
  assign irq_clr = (wr_ph_r && wr_ofs_r == `EAS_OFS_IRQ_CLR) ?
                   hwdata[`EAS_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      wr_ph_r <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_ofs_r <= {haddr[7:2], 2'b00};
      if (addr_ok && !hwrite)
        hrdata <= (haddr[31:8] == 24'h000000) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duplex_fitted_r <= `EAS_CTRL_RESET;
      irq_en_r <= `EAS_IRQ_EN_RESET;
    end else if (ce && wr_ph_r) begin
      if (wr_ofs_r == `EAS_OFS_CTRL)
        duplex_fitted_r <= hwdata[`EAS_CTRL_DUPLEX_BIT];
      if (wr_ofs_r == `EAS_OFS_IRQ_EN)
        irq_en_r <= hwdata[`EAS_IRQ_WIDTH-1:0];
    end
  end

  logic unused_ok;
  assign unused_ok = ^{hsize, htrans[0]};

endmodule
`default_nettype wire

// ==== test/eas_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module eas_far_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench controls
  input wire logic consume,
  input wire logic hopper_empty,
  // Drive from the block
  input wire logic toner_motor_on,
  input wire logic heater_trigger_switch,
  input wire logic eng_cnt_coil,
  input wire logic dup_cnt_coil,
  // Sense lines and tallies
  output logic toner_low_level_n,
  output logic ac_zero_cross,
  output logic [31:0] eng_strokes,
  output logic [31:0] dup_strokes,
  output logic [31:0] heat_pulses
);
  logic dev_low_r;
  logic [5:0] ac_phase_r;
  logic [2:0] last_r;
  assign toner_low_level_n = !dev_low_r;
  // Mains runs free, so crossings also arrive outside heat demand
  assign ac_zero_cross = ac_phase_r < 6'h04;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_low_r <= 1'b0;
      ac_phase_r <= 6'h00;
      last_r <= 3'h0;
      eng_strokes <= 32'h0;
      dup_strokes <= 32'h0;
      heat_pulses <= 32'h0;
    end else begin
      ac_phase_r <= ac_phase_r + 6'h01;
      last_r <= {heater_trigger_switch, dup_cnt_coil, eng_cnt_coil};
      if (consume)
        dev_low_r <= 1'b1;
      else if (toner_motor_on && !hopper_empty)
        dev_low_r <= 1'b0;
      if (eng_cnt_coil && !last_r[0])
        eng_strokes <= eng_strokes + 32'h1;
      if (dup_cnt_coil && !last_r[1])
        dup_strokes <= dup_strokes + 32'h1;
      if (heater_trigger_switch && !last_r[2])
        heat_pulses <= heat_pulses + 32'h1;
    end
  end
endmodule

`default_nettype wire

// ==== test/eas_top_props.sv ====
`timescale 1ns/1ps
`default_nettype none

module eas_top_props #(
  parameter int HTR_PULSE_CYCLES = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Toner side
  input wire logic toner_low_level_n,
  input wire logic drum_motor_run,
  input wire logic power_sw_on,
  input wire logic doors_closed,
  input wire logic toner_motor_on,
  input wire logic add_toner,
  // Print and counters
  input wire logic print_cycle_active,
  input wire logic halt_print,
  input wire logic [3:0] error_code,
  input wire logic eng_cnt_open,
  input wire logic eng_cnt_coil,
  // Heater
  input wire logic drum_temp_sense_n,
  input wire logic heater_trigger_switch
);
  logic [12:0] hi_cnt_r;
  logic [2:0] sw_cnt_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Helper counts
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt_r <= 13'h0000;
      sw_cnt_r <= 3'h0;
    end else begin
      hi_cnt_r <= heater_trigger_switch ? hi_cnt_r + 13'h0001 : 13'h0000;
      if (!(power_sw_on && doors_closed))
        sw_cnt_r <= 3'h0;
      else if (sw_cnt_r != 3'h4)
        sw_cnt_r <= sw_cnt_r + 3'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  pulse_cap_a: assert property (hi_cnt_r <= HTR_PULSE_CYCLES)
    else $error("heater pulse too long");
  heat_off_a: assert property (
    drum_temp_sense_n [*5] |-> !heater_trigger_switch)
    else $error("trigger without demand");
  motor_drum_a: assert property (
    toner_motor_on |-> $past(drum_motor_run, 2) || $past(drum_motor_run, 3))
    else $error("supply motor without drum");
  motor_low_a: assert property (
    toner_motor_on |-> !$past(toner_low_level_n, 2) ||
    !$past(toner_low_level_n, 3))
    else $error("supply motor without toner low");
  add_hold_a: assert property (
    add_toner && sw_cnt_r == 3'h4 |=> add_toner)
    else $error("add toner dropped");
  halt_wait_a: assert property (
    (add_toner && !print_cycle_active) [*4] |-> halt_print)
    else $error("no halt after add toner");
  fault_err_a: assert property (
    eng_cnt_open [*6] |-> error_code != 4'h0 && halt_print)
    else $error("open counter not flagged");
  err_latch_a: assert property (
    error_code != 4'h0 |=> $stable(error_code) && halt_print)
    else $error("counter error not latched");
  coil_len_a: assert property (
    $rose(eng_cnt_coil) |-> eng_cnt_coil [*8])
    else $error("count stroke too short");
  add_c: cover property ($rose(add_toner));
  heat_c: cover property ($rose(heater_trigger_switch));
  err_c: cover property ($rose(halt_print) && error_code != 4'h0);
endmodule

bind eas_top eas_top_props #(.HTR_PULSE_CYCLES(HTR_PULSE_CYCLES)) i_props (
  .hclk, .hresetn, .toner_low_level_n, .drum_motor_run, .power_sw_on,
  .doors_closed, .toner_motor_on, .add_toner, .print_cycle_active,
  .halt_print, .error_code, .eng_cnt_open, .eng_cnt_coil,
  .drum_temp_sense_n, .heater_trigger_switch);

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eas_params.svh"

module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic drum_motor_run = 1'b0;
  logic power_sw_on = 1'b1;
  logic doors_closed = 1'b1;
  logic print_cycle_active = 1'b0;
  logic image_done = 1'b0;
  logic return_pass_image = 1'b0;
  logic duplex_sheet_in = 1'b0;
  logic eng_cnt_open = 1'b0;
  logic dup_cnt_open = 1'b0;
  logic drum_temp_sense_n = 1'b1;
  logic consume = 1'b0;
  logic hopper_empty = 1'b0;
  logic hreadyout, hresp, toner_motor_on, add_toner, halt_print, irq;
  logic toner_low_level_n, ac_zero_cross, heater_trigger_switch;
  logic eng_cnt_coil, dup_cnt_coil;
  logic [3:0] error_code;
  logic [31:0] hrdata, v, h0, eng_strokes, dup_strokes, heat_pulses;
  int n;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  eas_top #(.TICK_CYCLES(1), .HTR_PULSE_CYCLES(8)) i_eas_top (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .toner_low_level_n, .drum_motor_run, .power_sw_on, .doors_closed,
    .toner_motor_on, .add_toner, .print_cycle_active, .image_done,
    .return_pass_image, .duplex_sheet_in, .halt_print, .error_code,
    .eng_cnt_open, .dup_cnt_open, .eng_cnt_coil, .dup_cnt_coil,
    .drum_temp_sense_n, .ac_zero_cross, .heater_trigger_switch, .irq);

  eas_far_model i_eas_far_model (
    .hclk, .hresetn, .consume, .hopper_empty, .toner_motor_on,
    .heater_trigger_switch, .eng_cnt_coil, .dup_cnt_coil,
    .toner_low_level_n, .ac_zero_cross, .eng_strokes, .dup_strokes,
    .heat_pulses);

  always #2.5 hclk = ~hclk;

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_cmp(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, v);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge hclk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Longest wait is the full supply time plus a margin
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 115000) begin
      errors++;
      stop_test;
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    idle(10);
    hresetn <= 1'b1;
    idle(2);
    rd_cmp("ctrl", `EAS_OFS_CTRL, 32'h0);
    rd_cmp("irq_en", `EAS_OFS_IRQ_EN, 32'h0);
    rd_cmp("unmapped", 8'h40, 32'h0);
    cmp("okay", 32'h2, {30'h0, hreadyout, hresp});
    bus(1'b1, `EAS_OFS_IRQ_EN, 32'h1);
    rd_cmp("irq_en", `EAS_OFS_IRQ_EN, 32'h1);
    $display("test registers done");
    h0 = heat_pulses;
    idle(300);
    cmp("no_demand", h0, heat_pulses);
    drum_temp_sense_n <= 1'b0;
    idle(300);
    cmp("demand", 32'h1, {31'h0, heat_pulses - h0 >= 32'h3});
    drum_temp_sense_n <= 1'b1;
    idle(20);
    cmp("trigger_off", 32'h0, {31'h0, heater_trigger_switch});
    $display("test heater done");
    {image_done, return_pass_image, duplex_sheet_in} <= 3'h7;
    @(posedge hclk);
    {image_done, return_pass_image, duplex_sheet_in} <= 3'h0;
    bus(1'b1, `EAS_OFS_CTRL, 32'h1);
    image_done <= 1'b1;
    duplex_sheet_in <= 1'b1;
    @(posedge hclk);
    return_pass_image <= 1'b1;
    duplex_sheet_in <= 1'b0;
    @(posedge hclk);
    image_done <= 1'b0;
    return_pass_image <= 1'b0;
    idle(400);
    rd_cmp("eng_count", `EAS_OFS_ENG_COUNT, 32'h4);
    rd_cmp("dup_count", `EAS_OFS_DUP_COUNT, 32'h1);
    cmp("eng_strokes", 32'h4, eng_strokes);
    cmp("dup_strokes", 32'h1, dup_strokes);
    $display("test counters done");
    drum_motor_run <= 1'b1;
    consume <= 1'b1;
    @(posedge hclk);
    consume <= 1'b0;
    idle(50);
    cmp("refilled", 32'h0, {31'h0, toner_motor_on});
    hopper_empty <= 1'b1;
    consume <= 1'b1;
    @(posedge hclk);
    consume <= 1'b0;
    idle(10);
    cmp("motor_on", 32'h1, {31'h0, toner_motor_on});
    idle(500);
    drum_motor_run <= 1'b0;
    idle(5);
    bus(1'b0, `EAS_OFS_ACCUM, 32'h0);
    h0 = v;
    cmp("accum_run", 32'h1, {31'h0, h0 > 32'h1F3});
    idle(100);
    rd_cmp("accum_hold", `EAS_OFS_ACCUM, h0);
    doors_closed <= 1'b0;
    idle(5);
    rd_cmp("accum_door", `EAS_OFS_ACCUM, 32'h0);
    doors_closed <= 1'b1;
    idle(50);
    rd_cmp("accum_idle", `EAS_OFS_ACCUM, 32'h0);
    print_cycle_active <= 1'b1;
    drum_motor_run <= 1'b1;
    n = 0;
    while (add_toner !== 1'b1 && n < 110000) begin
      @(posedge hclk);
      n++;
    end
    cmp("add_time", 32'h1, {31'h0, n >= `EAS_SUPPLY_LIMIT_TICKS});
    idle(5);
    cmp("halt_wait", 32'h0, {31'h0, halt_print});
    cmp("irq_set", 32'h1, {31'h0, irq});
    print_cycle_active <= 1'b0;
    idle(5);
    cmp("halt", 32'h1, {31'h0, halt_print});
    rd_cmp("irq_stat", `EAS_OFS_IRQ_STAT, 32'h1);
    bus(1'b1, `EAS_OFS_IRQ_CLR, 32'h1);
    idle(1);
    cmp("irq_clear", 32'h0, {31'h0, irq});
    idle(50);
    cmp("add_hold", 32'h1, {31'h0, add_toner});
    power_sw_on <= 1'b0;
    drum_motor_run <= 1'b0;
    idle(5);
    cmp("add_clear", 32'h0, {31'h0, add_toner});
    rd_cmp("accum_power", `EAS_OFS_ACCUM, 32'h0);
    power_sw_on <= 1'b1;
    $display("test toner done");
    {eng_cnt_open, dup_cnt_open} <= 2'h3;
    idle(10);
    cmp("err_code", `EAS_ERR_ENG_COUNTER, {28'h0, error_code});
    cmp("halt_fault", 32'h1, {31'h0, halt_print});
    eng_cnt_open <= 1'b0;
    idle(20);
    cmp("err_latch", `EAS_ERR_ENG_COUNTER, {28'h0, error_code});
    rd_cmp("irq_stat", `EAS_OFS_IRQ_STAT, 32'h6);
    rd_cmp("status", `EAS_OFS_STATUS, 32'h10E);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    image_done <= 1'b1;
    @(posedge hclk);
    image_done <= 1'b0;
    idle(100);
    cmp("no_stroke", 32'h4, eng_strokes);
    hresetn <= 1'b0;
    idle(10);
    hresetn <= 1'b1;
    idle(3);
    cmp("err_reset", 32'h0, {28'h0, error_code});
    $display("test faults done");
    stop_test;
  end
endmodule

`default_nettype wire
